// ### pkg/anar_pkg.sv
// Purpose: Shared constants and carrier types for the auto-negotiation ability registers.
// Assumes: 16-bit management registers reached through a plain register port.
// Notes: Register offsets are register numbers on the management port.

package anar_pkg;

  // Register map.
  localparam logic [4:0]  ADDR_LOCAL_ADV    = 5'h04;
  localparam logic [4:0]  ADDR_PARTNER_ABIL = 5'h05;
  localparam logic [4:0]  ADDR_CTRL_SHADOW  = 5'h10;

  // Advertisement field positions and resets.
  localparam int          ADV_10FD_BIT      = 6;
  localparam int          ADV_10HD_BIT      = 5;
  localparam int          SEL_MSB           = 4;
  localparam logic        ADV_10FD_RST      = 1'h1;
  localparam logic        ADV_10HD_RST      = 1'h1;
  localparam logic [4:0]  SEL_RST           = 5'h01;
  localparam logic [15:0] PARTNER_RST       = 16'h0000;

  // Control shadow field positions (register of our own).
  localparam int          CTL_SW_RESET_BIT  = 15;
  localparam int          CTL_AN_ENABLE_BIT = 12;
  localparam int          CTL_RESTART_BIT   = 9;
  localparam int          CTL_DUPLEX_BIT    = 8;

  // Control signals from the PHY control logic.
  typedef struct packed {
    logic sw_reset;
    logic restart_an;
    logic power_down;
    logic an_enable;
    logic forced_1000;
    logic duplex_full;
  } anar_ctrl_t;

  // Advertised ability handed to the auto-negotiation engine.
  typedef struct packed {
    logic       adv_1000fd;
    logic       adv_1000hd;
    logic       ignore_10_100;
    logic       adv_10fd;
    logic       adv_10hd;
    logic [4:0] selector;
  } anar_adv_t;

endpackage

// ### rtl/anar_pending_reg.sv
// Purpose: Holding register with a pending copy that is applied on an update event.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: A write and an apply in the same cycle apply the new write.

`timescale 1ns/100ps
`default_nettype none

module anar_pending_reg #(
  parameter int          WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Write and apply
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             apply,
  // Values
  output logic      [WIDTH-1:0] pending,
  output logic      [WIDTH-1:0] active
);

  logic [WIDTH-1:0] pend_q;
  logic [WIDTH-1:0] pend_d;
  logic [WIDTH-1:0] act_q;
  logic [WIDTH-1:0] act_d;

  always_comb begin
    pend_d = wr_en ? wr_data : pend_q;
    act_d  = apply ? pend_d : act_q;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= RST_VAL;
      act_q  <= RST_VAL;
    end else begin
      pend_q <= pend_d;
      act_q  <= act_d;
    end
  end

  assign pending = pend_q;
  assign active  = act_q;

endmodule // anar_pending_reg

`default_nettype wire

// ### rtl/anar_regs.sv
// Purpose: Local advertisement (low bits) and link partner base-page ability registers.
// Assumes: Control inputs and page capture come from logic on core_clk; link status is a pin.
// Notes: Read data stand one cycle after the read strobe and only then.
//
// Implementation choice: the plain strobed port.

`timescale 1ns/100ps
`default_nettype none

module anar_regs #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // PHY control state
  input  wire anar_pkg::anar_ctrl_t ctrl,
  // Copper link status pin
  input  wire logic              link_up_pin,
  // Received base page
  input  wire logic              page_valid,
  input  wire logic [DATA_W-1:0] page_word,
  // Advertised ability
  output var anar_pkg::anar_adv_t adv
);

  // Link status synchroniser.
  logic link_s1_q;
  logic link_s2_q;
  logic link_prev_q;
  logic pd_prev_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      link_s1_q       <= 1'b0;
      link_s2_q       <= 1'b0;
      link_prev_q     <= 1'b0;
      pd_prev_q       <= 1'b0;
    end else begin
      link_s1_q       <= link_up_pin;
      link_s2_q       <= link_s1_q;
      link_prev_q     <= link_s2_q;
      pd_prev_q       <= ctrl.power_down;
    end
  end

  // Update events for deferred advertisement writes.
  logic link_lost;
  logic pd_exit;
  logic apply_adv;

  assign link_lost = link_prev_q & ~link_s2_q;
  assign pd_exit   = pd_prev_q & ~ctrl.power_down;
  assign apply_adv = ctrl.sw_reset | ctrl.restart_an | pd_exit | link_lost;

  // Decode.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  logic wr_adv;
  assign wr_adv = reg_wr & hit(reg_addr, anar_pkg::ADDR_LOCAL_ADV);

  // 10 Mb/s duplex advertisement, deferred.
  logic [1:0] adv10_pend;
  logic [1:0] adv10_act;

  anar_pending_reg #(
    .WIDTH   (2),
    .RST_VAL ({anar_pkg::ADV_10FD_RST, anar_pkg::ADV_10HD_RST})
  ) u_adv10 (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wr_en    (wr_adv),
    .wr_data  (reg_wdata[anar_pkg::ADV_10FD_BIT:anar_pkg::ADV_10HD_BIT]),
    .apply    (apply_adv),
    .pending  (adv10_pend),
    .active   (adv10_act)
  );

  // Selector: written directly, software reset leaves it alone.
  logic [4:0] sel_q;
  logic [4:0] sel_d;

  always_comb begin
    sel_d = sel_q;
    if (wr_adv) begin
      sel_d = reg_wdata[anar_pkg::SEL_MSB:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= anar_pkg::SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Partner base-page ability.
  logic [DATA_W-1:0] partner_q;
  logic [DATA_W-1:0] partner_d;

  always_comb begin
    partner_d = partner_q;
    if (ctrl.sw_reset) begin
      partner_d = anar_pkg::PARTNER_RST;
    end else if (page_valid) begin
      // Bit for bit: 15 NP, 14 ack, 13 RF, 12 tech, 11 asym, 10 pause, 9..5 abilities, 4..0 sel.
      partner_d = page_word;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      partner_q <= anar_pkg::PARTNER_RST;
    end else begin
      partner_q <= partner_d;
    end
  end

  // Advertised ability and forced-1000 override.
  anar_pkg::anar_adv_t adv_q;
  anar_pkg::anar_adv_t adv_d;
  logic                forced_gig;

  // Autoneg stays running when forced to 1000; software is expected not to rely on that.
  assign forced_gig = ~ctrl.an_enable & ctrl.forced_1000;

  always_comb begin
    adv_d.selector      = sel_q;
    adv_d.ignore_10_100 = forced_gig;
    adv_d.adv_10fd      = forced_gig ? 1'b0 : adv10_act[1];
    adv_d.adv_10hd      = forced_gig ? 1'b0 : adv10_act[0];
    adv_d.adv_1000fd    = forced_gig & ctrl.duplex_full;
    adv_d.adv_1000hd    = forced_gig & ~ctrl.duplex_full;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      adv_q <= '0;
    end else begin
      adv_q <= adv_d;
    end
  end

  assign adv = adv_q;

  // Read port; the advertisement reads back the written (pending) value.
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      if (hit(reg_addr, anar_pkg::ADDR_LOCAL_ADV)) begin
        rdata_d[anar_pkg::ADV_10FD_BIT:anar_pkg::ADV_10HD_BIT] = adv10_pend;
        rdata_d[anar_pkg::SEL_MSB:0] = sel_q;
      end else if (hit(reg_addr, anar_pkg::ADDR_PARTNER_ABIL)) begin
        rdata_d = partner_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // anar_regs

`default_nettype wire

// ### tb/anar_chk.sv
// Purpose: Port checker for the ability registers.
// Assumes: One clock domain, rstn asynchronous and active low.
// Notes: Bound to anar_regs at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module anar_chk (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rstn,
  // Register port
  input wire logic [4:0]           reg_addr,
  input wire logic [15:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [15:0]          reg_rdata,
  // Control, line side and advertisement
  input wire anar_pkg::anar_ctrl_t ctrl,
  input wire logic                 link_up_pin,
  input wire logic                 page_valid,
  input wire logic [15:0]          page_word,
  input wire anar_pkg::anar_adv_t  adv
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic       wr4 = reg_wr && reg_addr == anar_pkg::ADDR_LOCAL_ADV;
  wire logic       rd5 = reg_rd && reg_addr == anar_pkg::ADDR_PARTNER_ABIL;
  wire logic       hot = ctrl.sw_reset || ctrl.restart_an;
  wire logic [1:0] a10 = {adv.adv_10fd, adv.adv_10hd};
  page_load_a: assert property (page_valid && !hot ##1 rd5 && !hot && !page_valid
    |=> reg_rdata == $past(page_word, 2)) else $error("partner word not loaded");
  partner_clr_a: assert property (ctrl.sw_reset ##1 rd5 && !page_valid
    |=> reg_rdata == 16'h0000) else $error("partner not cleared");
  sel_wr_a: assert property (wr4 |-> ##2 adv.selector == $past(reg_wdata[4:0], 2))
    else $error("selector write lost");
  sel_keep_a: assert property (ctrl.sw_reset && !wr4 && !$past(wr4) && $past(rstn)
    |=> $stable(adv.selector)) else $error("selector changed by reset");
  hold_pend_a: assert property (wr4 && !hot && ctrl == $past(ctrl) && ctrl == $past(ctrl, 2)
    && $past(rstn, 2) && $past(link_up_pin, 5) && link_up_pin
    |-> ##2 a10 == $past(a10, 2)) else $error("write applied early");
  apply_a: assert property (wr4 && ctrl.an_enable ##1 hot && !reg_wr && ctrl.an_enable
    |=> ##1 a10 == $past(reg_wdata[6:5], 3)) else $error("write not applied");
  pd_exit_a: assert property (wr4 && ctrl.an_enable ##1 $fell(ctrl.power_down) && !reg_wr
    |-> ##2 a10 == $past(reg_wdata[6:5], 3)) else $error("power-up apply missing");
  forced_a: assert property (!ctrl.an_enable && ctrl.forced_1000 |=> adv.ignore_10_100
    && a10 == 2'h0 && adv.adv_1000fd == $past(ctrl.duplex_full)
    && adv.adv_1000hd != $past(ctrl.duplex_full)) else $error("forced advertise wrong");
endmodule // anar_chk
bind anar_regs anar_chk anar_chk_i (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl(ctrl),
  .link_up_pin(link_up_pin), .page_valid(page_valid), .page_word(page_word), .adv(adv));
`default_nettype wire

// ### tb/anar_partner.sv
// Purpose: Remote link partner delivering base pages and link status.
// Assumes: Pages arrive already decoded on core_clk.
// Notes: The word line shows junk outside the valid pulse.
`timescale 1ns/100ps
`default_nettype none
module anar_partner (
  // Clock and bench requests
  input wire logic         core_clk,
  input wire logic         send,
  input wire logic [15:0]  word,
  input wire logic         link,
  // Line side
  output var logic         page_valid,
  output var logic [15:0]  page_word,
  output var logic         link_up_pin
);
  initial begin
    page_valid = 1'h0;
    page_word = 16'h0000;
    link_up_pin = 1'h1;
  end
  // Inverting the idle word keeps a stale page from passing as a fresh one.
  always @(posedge core_clk) begin
    page_valid <= send;
    page_word <= send ? word : ~page_word;
    link_up_pin <= link;
  end
endmodule // anar_partner
`default_nettype wire

// ### tb/test_autoneg_ability_registers.sv
// Purpose: Directed register and advertisement tests.
// Assumes: adv settles within three edges of its cause; a link drop takes five edges from the link request.
// Notes: ctrl bits are flipped one cycle at a time.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module test_autoneg_ability_registers;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic send = 1'h0;
  logic link = 1'h1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] word = 16'h0000;
  logic [15:0] d;
  logic [15:0] reg_rdata;
  logic [15:0] page_word;
  logic page_valid;
  logic link_up_pin;
  anar_pkg::anar_ctrl_t ctrl = 6'h04;
  anar_pkg::anar_adv_t adv;
  int err_count = 0;
  int total_checks = 0;
  anar_regs anar_regs_i (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ctrl(ctrl), .link_up_pin(link_up_pin), .page_valid(page_valid),
    .page_word(page_word), .adv(adv));
  anar_partner anar_partner_i (.core_clk(core_clk), .send(send), .word(word), .link(link),
    .page_valid(page_valid), .page_word(page_word), .link_up_pin(link_up_pin));
  initial forever #20 core_clk = ~core_clk;
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    wt(1);
    reg_wr <= 1'h0;
    wt(1);
  endtask
  task automatic rd(input logic [4:0] a);
    reg_addr <= a;
    reg_rd <= 1'h1;
    wt(1);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
    wt(1);
  endtask
  task automatic tog(input int b);
    ctrl[b] <= !ctrl[b];
    wt(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    wt(16);
    rstn <= 1'h1;
    wt(2);
    rd(5'h04); `CHK("adv reg", 16'h0061, d)
    `CHK("adv out", 10'h061, adv)
    rd(5'h1F); `CHK("unmapped", 16'h0000, d)
    wr(5'h04, 16'hFF82);
    rd(5'h04); `CHK("adv reg", 16'h0002, d)
    wt(2); `CHK("pending", 10'h062, adv)
    tog(4); tog(4); wt(2); `CHK("restart", 10'h002, adv)
    word <= 16'hA5E3; send <= 1'h1; wt(1); send <= 1'h0; wt(1);
    rd(5'h05); `CHK("partner new", 16'hA5E3, d)
    wr(5'h05, 16'hFFFF);
    rd(5'h05); `CHK("partner", 16'hA5E3, d)
    wr(5'h04, 16'h0042); wt(2); `CHK("pending", 10'h002, adv)
    tog(5); tog(5); wt(2); `CHK("sw reset", 10'h042, adv)
    rd(5'h05); `CHK("partner clr", 16'h0000, d)
    wr(5'h04, 16'h0022); tog(3); wt(3); `CHK("pd", 10'h042, adv)
    tog(3); wt(3); `CHK("pd exit", 10'h022, adv)
    wr(5'h04, 16'h0062); link <= 1'h0; wt(8); `CHK("link", 10'h062, adv)
    link <= 1'h1; wt(4);
    tog(2); tog(1); tog(0); wt(2); `CHK("forced fd", 10'h282, adv)
    tog(0); wt(2); `CHK("forced hd", 10'h182, adv)
    tog(1); tog(2); wt(2); `CHK("autoneg", 10'h062, adv)
    // A write followed at once by the power-up edge must be the value applied.
    tog(3);
    reg_addr <= 5'h04;
    reg_wdata <= 16'h0041;
    reg_wr <= 1'h1;
    wt(1);
    reg_wr <= 1'h0;
    ctrl.power_down <= 1'h0;
    wt(3); `CHK("pd fast", 10'h041, adv)
    // A write followed at once by a restart must be the value applied.
    reg_wdata <= 16'h0021;
    reg_wr <= 1'h1;
    wt(1);
    reg_wr <= 1'h0;
    ctrl.restart_an <= 1'h1;
    wt(1);
    ctrl.restart_an <= 1'h0;
    wt(2); `CHK("restart fast", 10'h021, adv)
    report_and_stop();
  end
endmodule // test_autoneg_ability_registers
`undef CHK
`default_nettype wire
